/* File: rtl/cbaf_core.sv */
// Core SFR block: banked indirect addressing, PC low jump, table pointers,
// flag register. Assumes a datapath on the same clock, an async-read data RAM,
// and an APB master for software access.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cbaf_defs.svh"

module cbaf_core
  import cbaf_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic        i_soft_reset,
  input  wire logic        i_reset_wdt_pd,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire cbaf_req_s   i_req,
  output logic      [7:0]  o_rdata,
  output logic             o_rvalid,
  output cbaf_mem_s        o_mem,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire cbaf_alu_s   i_alu,
  input  wire logic        i_halt,
  input  wire logic        i_watchdog_clear_instruction,
  input  wire logic        i_wdt_timeout,
  input  wire logic [10:0] i_pc,
  output logic             o_jump,
  output logic      [10:0] o_jump_addr,
  output logic      [10:0] o_tab_addr,
  input  wire logic        i_tab_done,
  input  wire logic [15:0] i_tab_word,
  output logic      [7:0]  o_tab_low,
  output logic      [7:0]  o_flags
);

  logic [7:0] ptr_a_q;
  logic [7:0] ptr_b_q;
  logic       bank_q;
  logic [7:0] tbl_lo_q;
  logic [7:0] tbl_hi_q;
  logic [7:0] tbl_latch_q;
  logic [3:0] arith_q;
  logic       pdf_q;
  logic       to_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       jump_q;
  logic [10:0] jump_addr_q;
  logic [7:0] tab_low_q;
  logic [31:0] prdata_q;

  // Resolved datapath access
  logic [7:0] ea;
  logic       ea_bank;
  logic       is_window;
  logic       null_acc;
  logic       own_hit;
  logic [7:0] own_rdata;
  logic       dp_wr;

  // APB decode
  logic       apb_setup;
  logic       apb_wr;
  logic       apb_hit;

  // Flag byte as seen by reads
  function automatic logic [7:0] flag_byte(input logic to_f, input logic pdf_f,
                                           input logic [3:0] ar);
    flag_byte = {2'b00, to_f, pdf_f, ar};
  endfunction : flag_byte

  // Whether an address is one of the SFRs held in this block
  function automatic logic own_addr(input logic [7:0] a);
    own_addr = (a == `CBAF_A_PTR_A) || (a == `CBAF_A_PTR_B) ||
               (a == `CBAF_A_BANK) || (a == `CBAF_A_PCL) ||
               (a == `CBAF_A_TBL_LO) || (a == `CBAF_A_TBL_HI) ||
               (a == `CBAF_A_TBL_LATCH) || (a == `CBAF_A_FLAGS);
  endfunction : own_addr

  // New arithmetic flags {OV, Z, AC, C} for one ALU operation
  function automatic logic [3:0] alu_flags(input cbaf_alu_s u, input logic [3:0] old);
    logic [8:0] full;
    logic [4:0] nib;
    logic [7:0] low7;
    logic       c7;
    logic       c8;
    logic       zf;
    full = 9'h000;
    nib  = 5'h00;
    low7 = 8'h00;
    c7   = 1'b0;
    c8   = 1'b0;
    zf   = 1'b0;
    alu_flags = old;
    unique case (u.op)
      CBAF_OP_ADD: begin
        full = {1'b0, u.a} + {1'b0, u.b} + {8'h00, u.cin};
        nib  = {1'b0, u.a[3:0]} + {1'b0, u.b[3:0]} + {4'h0, u.cin};
        low7 = {1'b0, u.a[6:0]} + {1'b0, u.b[6:0]} + {7'h00, u.cin};
      end
      CBAF_OP_SUB: begin
        // Subtract as a + ~b + cin; carry out then means no borrow
        full = {1'b0, u.a} + {1'b0, ~u.b} + {8'h00, u.cin};
        nib  = {1'b0, u.a[3:0]} + {1'b0, ~u.b[3:0]} + {4'h0, u.cin};
        low7 = {1'b0, u.a[6:0]} + {1'b0, ~u.b[6:0]} + {7'h00, u.cin};
      end
      CBAF_OP_ROTC: begin
        alu_flags[`CBAF_F_C] = u.cin;
      end
      CBAF_OP_LOGIC: begin
        alu_flags[`CBAF_F_Z] = (u.result == 8'h00);
      end
      default: begin
        alu_flags = old;
      end
    endcase
    if (u.op == CBAF_OP_ADD || u.op == CBAF_OP_SUB) begin
      c8 = full[8];
      c7 = low7[7];
      zf = (full[7:0] == 8'h00);
      alu_flags[`CBAF_F_C]  = c8;
      alu_flags[`CBAF_F_AC] = nib[4];
      alu_flags[`CBAF_F_Z]  = zf;
      alu_flags[`CBAF_F_OV] = c7 ^ c8;
    end
  endfunction : alu_flags

  // Address resolution for the datapath
  always_comb begin
    is_window = 1'b0;
    ea        = i_req.addr;
    ea_bank   = 1'b0;
    if (i_req.addr == `CBAF_A_WIN_A) begin
      is_window = 1'b1;
      ea        = ptr_a_q;
      ea_bank   = 1'b0;
    end else if (i_req.addr == `CBAF_A_WIN_B) begin
      is_window = 1'b1;
      ea        = ptr_b_q;
      ea_bank   = bank_q;
    end
  end

  assign null_acc = is_window && (ea == `CBAF_A_WIN_A || ea == `CBAF_A_WIN_B);
  assign own_hit  = own_addr(ea);
  assign dp_wr    = i_ce && i_req.valid && i_req.write && own_hit && !null_acc;

  // Outside locations; bank only matters for general RAM and the store control
  always_comb begin
    o_mem.valid = i_req.valid && !own_hit && !null_acc;
    o_mem.write = i_req.write;
    o_mem.addr  = ea;
    o_mem.wdata = i_req.wdata;
    o_mem.bank  = ea_bank && (ea >= `CBAF_GPR_BASE || ea == `CBAF_A_NV_CTRL);
  end

  always_comb begin
    unique case (ea)
      `CBAF_A_PTR_A:     own_rdata = ptr_a_q;
      `CBAF_A_PTR_B:     own_rdata = ptr_b_q;
      `CBAF_A_BANK:      own_rdata = {7'h00, bank_q};
      `CBAF_A_PCL:       own_rdata = i_pc[7:0];
      `CBAF_A_TBL_LO:    own_rdata = tbl_lo_q;
      `CBAF_A_TBL_HI:    own_rdata = tbl_hi_q;
      `CBAF_A_TBL_LATCH: own_rdata = tbl_latch_q;
      `CBAF_A_FLAGS:     own_rdata = flag_byte(to_q, pdf_q, arith_q);
      default:           own_rdata = 8'h00;
    endcase
  end

  // Datapath read answer, one cycle after the request
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (i_ce) begin
      rvalid_q <= i_req.valid && !i_req.write;
      if (i_req.valid && !i_req.write) begin
        if (null_acc) begin
          rdata_q <= 8'h00;
        end else if (own_hit) begin
          rdata_q <= own_rdata;
        end else begin
          rdata_q <= i_mem_rdata;
        end
      end
    end
  end

  assign o_rdata  = rdata_q;
  assign o_rvalid = rvalid_q;

  // APB: zero wait states, read data latched in the setup cycle
  assign apb_setup = i_psel && !i_penable;
  assign apb_hit   = (i_paddr[1:0] == 2'b00) && (i_paddr <= `CBAF_P_PCL);
  assign apb_wr    = i_ce && i_psel && i_penable && i_pwrite && apb_hit;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !apb_hit;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (i_ce && apb_setup) begin
      unique case (i_paddr)
        `CBAF_P_BANK:      prdata_q <= {31'h0000_0000, bank_q};
        `CBAF_P_FLAGS:     prdata_q <= {24'h00_0000, flag_byte(to_q, pdf_q, arith_q)};
        `CBAF_P_PTR_A:     prdata_q <= {24'h00_0000, ptr_a_q};
        `CBAF_P_PTR_B:     prdata_q <= {24'h00_0000, ptr_b_q};
        `CBAF_P_TBL_LO:    prdata_q <= {24'h00_0000, tbl_lo_q};
        `CBAF_P_TBL_HI:    prdata_q <= {24'h00_0000, tbl_hi_q};
        `CBAF_P_TBL_LATCH: prdata_q <= {24'h00_0000, tbl_latch_q};
        `CBAF_P_PCL:       prdata_q <= {24'h00_0000, i_pc[7:0]};
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_prdata = prdata_q;

  // Pointers; datapath writes win over a same-cycle APB write
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ptr_a_q <= 8'h00;
      ptr_b_q <= 8'h00;
    end else if (dp_wr && ea == `CBAF_A_PTR_A) begin
      ptr_a_q <= i_req.wdata;
    end else if (dp_wr && ea == `CBAF_A_PTR_B) begin
      ptr_b_q <= i_req.wdata;
    end else if (apb_wr && i_paddr == `CBAF_P_PTR_A) begin
      ptr_a_q <= i_pwdata[7:0];
    end else if (apb_wr && i_paddr == `CBAF_P_PTR_B) begin
      ptr_b_q <= i_pwdata[7:0];
    end
  end

  // Bank select; a watchdog reset in power-down keeps the bank
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      bank_q <= `CBAF_BANK_RST;
    end else if (i_ce) begin
      if (i_soft_reset) begin
        if (!i_reset_wdt_pd) begin
          bank_q <= `CBAF_BANK_RST;
        end
      end else if (dp_wr && ea == `CBAF_A_BANK) begin
        bank_q <= i_req.wdata[0];
      end else if (apb_wr && i_paddr == `CBAF_P_BANK) begin
        bank_q <= i_pwdata[0];
      end
    end
  end

  // Jump on PC low write; the pulse also tells the datapath to insert a dummy cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      jump_q      <= 1'b0;
      jump_addr_q <= 11'h000;
    end else if (i_ce) begin
      jump_q <= dp_wr && ea == `CBAF_A_PCL;
      if (dp_wr && ea == `CBAF_A_PCL) begin
        jump_addr_q <= {i_pc[10:8], i_req.wdata};
      end
    end
  end

  assign o_jump      = jump_q;
  assign o_jump_addr = jump_addr_q;

  // Table pointers and latch
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tbl_lo_q <= 8'h00;
      tbl_hi_q <= 8'h00;
    end else if (dp_wr && ea == `CBAF_A_TBL_LO) begin
      tbl_lo_q <= i_req.wdata;
    end else if (dp_wr && ea == `CBAF_A_TBL_HI) begin
      tbl_hi_q <= i_req.wdata;
    end else if (apb_wr && i_paddr == `CBAF_P_TBL_LO) begin
      tbl_lo_q <= i_pwdata[7:0];
    end else if (apb_wr && i_paddr == `CBAF_P_TBL_HI) begin
      tbl_hi_q <= i_pwdata[7:0];
    end
  end

  // Only three high bits reach a 2K-word program space
  assign o_tab_addr = {tbl_hi_q[2:0], tbl_lo_q};

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tbl_latch_q <= 8'h00;
      tab_low_q   <= 8'h00;
    end else if (i_ce && i_tab_done) begin
      tbl_latch_q <= i_tab_word[15:8];
      tab_low_q   <= i_tab_word[7:0];
    end else if (dp_wr && ea == `CBAF_A_TBL_LATCH) begin
      tbl_latch_q <= i_req.wdata;
    end
  end

  assign o_tab_low = tab_low_q;

  // Arithmetic flags; an ALU update in the same cycle beats a register write
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      arith_q <= `CBAF_ARITH_RST;
    end else if (i_ce) begin
      if (i_alu.valid) begin
        arith_q <= alu_flags(i_alu, arith_q);
      end else if (dp_wr && ea == `CBAF_A_FLAGS) begin
        arith_q <= i_req.wdata[3:0];
      end else if (apb_wr && i_paddr == `CBAF_P_FLAGS) begin
        arith_q <= i_pwdata[3:0];
      end
    end
  end

  // System flags: untouched by writes and by soft resets
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pdf_q <= 1'b0;
    end else if (i_ce) begin
      if (i_halt) begin
        pdf_q <= 1'b1;
      end else if (i_watchdog_clear_instruction) begin
        pdf_q <= 1'b0;
      end
    end
  end

  // Expiry wins over a clear in the same cycle so no timeout is lost
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      to_q <= 1'b0;
    end else if (i_ce) begin
      if (i_wdt_timeout) begin
        to_q <= 1'b1;
      end else if (i_watchdog_clear_instruction || i_halt) begin
        to_q <= 1'b0;
      end
    end
  end

  // No save path exists; software must stack the flags itself
  assign o_flags = flag_byte(to_q, pdf_q, arith_q);

endmodule : cbaf_core

/* File: rtl/cbaf_defs.svh */
// Offsets, field positions, reset values for the core banked SFR block.
// Included by the package and the design; definitions only.
`ifndef CBAF_DEFS_SVH
`define CBAF_DEFS_SVH

// Data-memory addresses of the SFRs held here, then the outside store control and the start of general RAM
`define CBAF_A_WIN_A     8'h00
`define CBAF_A_PTR_A     8'h01
`define CBAF_A_WIN_B     8'h02
`define CBAF_A_PTR_B     8'h03
`define CBAF_A_BANK      8'h04
`define CBAF_A_PCL       8'h06
`define CBAF_A_TBL_LO    8'h07
`define CBAF_A_TBL_LATCH 8'h08
`define CBAF_A_TBL_HI    8'h09
`define CBAF_A_FLAGS     8'h0A
`define CBAF_A_NV_CTRL   8'h40
`define CBAF_GPR_BASE    8'h80

// APB byte offsets
`define CBAF_P_BANK      8'h00
`define CBAF_P_FLAGS     8'h04
`define CBAF_P_PTR_A     8'h08
`define CBAF_P_PTR_B     8'h0C
`define CBAF_P_TBL_LO    8'h10
`define CBAF_P_TBL_HI    8'h14
`define CBAF_P_TBL_LATCH 8'h18
`define CBAF_P_PCL       8'h1C

// Flag register fields
`define CBAF_F_C         0
`define CBAF_F_AC        1
`define CBAF_F_Z         2
`define CBAF_F_OV        3
`define CBAF_F_PDF       4
`define CBAF_F_TO        5

`define CBAF_BANK_RST    1'b0
`define CBAF_ARITH_RST   4'h0
`define CBAF_NV_BYTES    64
`endif

/* File: rtl/cbaf_pkg.sv */
// Types shared by the core banked SFR block and its surroundings.
// Assumes cbaf_defs.svh on the include path.
package cbaf_pkg;
  `include "cbaf_defs.svh"

  typedef enum logic [2:0] {
    CBAF_OP_ADD  = 3'b000,
    CBAF_OP_SUB  = 3'b001,
    CBAF_OP_ROTC = 3'b010,
    CBAF_OP_LOGIC = 3'b011
  } cbaf_op_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbaf_req_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbaf_mem_s;

  typedef struct packed {
    logic       valid;
    cbaf_op_e   op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] result;
  } cbaf_alu_s;
endpackage : cbaf_pkg

/* File: verification/cbaf_core_sva.sv */
// Checker for cbaf_core: flags, jump, table low byte and banked addressing.
// Assumes one clock domain, async active-high reset, bound to cbaf_core.
`timescale 1ns/1ps
module cbaf_core_sva
  import cbaf_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_ce,
  input wire cbaf_req_s   i_req,
  input wire logic        o_rvalid,
  input wire cbaf_mem_s   o_mem,
  input wire cbaf_alu_s   i_alu,
  input wire logic        i_halt,
  input wire logic        i_watchdog_clear_instruction,
  input wire logic        i_wdt_timeout,
  input wire logic [10:0] i_pc,
  input wire logic        o_jump,
  input wire logic [10:0] o_jump_addr,
  input wire logic        i_tab_done,
  input wire logic [15:0] i_tab_word,
  input wire logic [7:0]  o_tab_low,
  input wire logic [7:0]  o_flags
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic [8:0]  sum;
  logic        res_z;
  logic [10:0] jmp_exp;
  assign sum     = {1'b0, i_alu.a} + {1'b0, i_alu.b} + 9'(i_alu.cin);
  assign res_z   = (i_alu.result == 8'h00);
  assign jmp_exp = {i_pc[10:8], i_req.wdata};
  sequence pcl_wr;
    i_ce && i_req.valid && i_req.write && i_req.addr == 8'h06;
  endsequence
  flag_pad_a: assert property (o_flags[7:6] == 2'b00)
    else $error("flag pad bits not zero");
  pcl_jump_a: assert property (pcl_wr |=> o_jump && o_jump_addr == $past(jmp_exp))
    else $error("page jump wrong");
  tab_low_a: assert property (i_ce && i_tab_done |=> o_tab_low == $past(i_tab_word[7:0]))
    else $error("table low byte wrong");
  halt_pd_a: assert property (i_ce && i_halt |=> o_flags[4])
    else $error("halt did not set power-down");
  expiry_to_a: assert property (i_ce && i_wdt_timeout |=> o_flags[5])
    else $error("expiry did not set timeout");
  wdt_clear_a: assert property (i_ce && i_watchdog_clear_instruction && !i_halt && !i_wdt_timeout
    |=> o_flags[5:4] == 2'b00)
    else $error("watchdog clear left flags");
  sys_hold_a: assert property (!(i_ce && (i_halt || i_watchdog_clear_instruction || i_wdt_timeout))
    |=> $stable(o_flags[5:4]))
    else $error("system flags changed");
  ce_freeze_a: assert property (!i_ce
    |=> $stable(o_flags) && $stable(o_tab_low) && $stable(o_jump_addr))
    else $error("state moved while clock enable low");
  add_flags_a: assert property (i_ce && i_alu.valid && i_alu.op == CBAF_OP_ADD
    |=> o_flags[0] == $past(sum[8]) && o_flags[2] == $past(res_z))
    else $error("add flags wrong");
  read_ans_a: assert property (i_ce && i_req.valid && !i_req.write |=> o_rvalid)
    else $error("read not answered");
  direct_bank_a: assert property (i_req.valid && i_req.addr >= 8'h80
    |-> o_mem.valid && !o_mem.bank && o_mem.addr == i_req.addr)
    else $error("direct access not bank 0");
  win_a_bank_a: assert property (i_req.valid && i_req.addr == 8'h00 && o_mem.valid
    |-> !o_mem.bank)
    else $error("window A left bank 0");
endmodule : cbaf_core_sva

bind cbaf_core cbaf_core_sva cbaf_core_sva_inst (.i_ref_clk, .i_reset, .i_ce, .i_req,
  .o_rvalid, .o_mem, .i_alu, .i_halt, .i_watchdog_clear_instruction, .i_wdt_timeout, .i_pc, .o_jump,
  .o_jump_addr, .i_tab_done, .i_tab_word, .o_tab_low, .o_flags);

/* File: verification/testbench.sv */
// Self-checking bench for cbaf_core over APB and the datapath ports.
// Assumes the package, its header and the bound checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import cbaf_pkg::*;
  logic        i_ref_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1;
  logic        i_soft_reset = 1'b0, i_reset_wdt_pd = 1'b0;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00, i_mem_rdata = 8'h5A, o_rdata, o_tab_low, o_flags;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic        o_pready, o_pslverr, o_rvalid, o_jump, e, i_tab_done = 1'b0;
  logic        i_halt, i_watchdog_clear_instruction, i_wdt_timeout;
  logic [2:0]  sys_ev = 3'b000;
  logic [10:0] i_pc = 11'h000, o_jump_addr, o_tab_addr;
  logic [15:0] i_tab_word = 16'h0000;
  cbaf_req_s   i_req = '0;
  cbaf_alu_s   i_alu = '0;
  cbaf_mem_s   o_mem, m;
  int          miscompares = 0, cmp_count = 0, cycles = 0;
  assign {i_halt, i_watchdog_clear_instruction, i_wdt_timeout} = sys_ev;
  cbaf_core cbaf_core_inst (.i_ref_clk, .i_reset, .i_ce, .i_soft_reset, .i_reset_wdt_pd,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_req, .o_rdata, .o_rvalid, .o_mem, .i_mem_rdata, .i_alu, .i_halt, .i_watchdog_clear_instruction,
    .i_wdt_timeout, .i_pc, .o_jump, .o_jump_addr, .o_tab_addr, .i_tab_done, .i_tab_word,
    .o_tab_low, .o_flags);
  always #5 i_ref_clk = ~i_ref_clk;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask : rd
  // Drives one datapath access; o_mem is caught in the request cycle
  task automatic dp(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_req <= '{1'b1, w, a, d};
    #1 m = o_mem;
    @(posedge i_ref_clk);
    i_req.valid <= 1'b0;
    #1 chk("rvalid", {31'h0, !w}, {31'h0, o_rvalid});
  endtask : dp
  task automatic alu(input cbaf_op_e op, input logic [7:0] a, b, input logic c,
                     input logic [7:0] r);
    @(posedge i_ref_clk);
    i_alu <= '{1'b1, op, a, b, c, r};
    @(posedge i_ref_clk);
    i_alu.valid <= 1'b0;
    #1;
  endtask : alu
  task automatic sys(input logic [2:0] v);
    @(posedge i_ref_clk);
    sys_ev <= v;
    @(posedge i_ref_clk);
    sys_ev <= 3'b000;
    #1;
  endtask : sys
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(8'h00, 32'h0, "bank_rst");
    rd(8'h04, 32'h0, "flags_rst");
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h1, "bank_rw");
    apb(1'b1, 8'h04, 32'hFF);
    rd(8'h04, 32'h0F, "flags_rw");
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    $display("test registers done");
    apb(1'b1, 8'h0C, 32'h85);
    apb(1'b1, 8'h08, 32'h90);
    dp(1'b0, 8'h02, 8'h00);
    chk("win_b_mem", {1'b1, 1'b0, 1'b1, 8'h85, 8'h00}, m);
    chk("win_b_data", 32'h5A, o_rdata);
    dp(1'b0, 8'h85, 8'h00);
    chk("direct_mem", {1'b1, 1'b0, 1'b0, 8'h85, 8'h00}, m);
    dp(1'b0, 8'h00, 8'h00);
    chk("win_a_mem", {1'b1, 1'b0, 1'b0, 8'h90, 8'h00}, m);
    dp(1'b0, 8'h03, 8'h00);
    chk("sfr_read", 32'h85, o_rdata);
    chk("sfr_local", 32'h0, {31'h0, m.valid});
    apb(1'b1, 8'h0C, 32'h40);
    dp(1'b1, 8'h02, 8'h0A);
    chk("nv_ctrl", {1'b1, 1'b1, 1'b1, 8'h40, 8'h0A}, m);
    apb(1'b1, 8'h0C, 32'h02);
    dp(1'b0, 8'h02, 8'h00);
    chk("self_read", 32'h0, o_rdata);
    chk("self_mem", 32'h0, {31'h0, m.valid});
    $display("test addressing done");
    @(posedge i_ref_clk);
    i_reset_wdt_pd <= 1'b1;
    i_soft_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_soft_reset <= 1'b0;
    rd(8'h00, 32'h1, "bank_pd_keep");
    i_reset_wdt_pd <= 1'b0;
    i_soft_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_soft_reset <= 1'b0;
    rd(8'h00, 32'h0, "bank_soft");
    // Clock enable low must freeze both the bank and the system flags
    i_ce <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    sys(3'b100);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    chk("ce_flags", 32'h0, o_flags[5:4]);
    rd(8'h00, 32'h0, "ce_bank");
    $display("test resets done");
    i_pc <= 11'h5AB;
    dp(1'b1, 8'h06, 8'h3C);
    chk("jump", 32'h1, {31'h0, o_jump});
    chk("jump_addr", 32'h53C, {21'h0, o_jump_addr});
    apb(1'b1, 8'h10, 32'h06);
    apb(1'b1, 8'h14, 32'h07);
    // Write lands at the task's last edge; look one edge later
    @(posedge i_ref_clk);
    chk("tab_addr", 32'h706, {21'h0, o_tab_addr});
    i_tab_word <= 16'h1A2B;
    i_tab_done <= 1'b1;
    @(posedge i_ref_clk);
    i_tab_done <= 1'b0;
    #1 chk("tab_low", 32'h2B, o_tab_low);
    rd(8'h18, 32'h1A, "tab_latch");
    $display("test jump and table done");
    alu(CBAF_OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80);
    chk("add", 32'hA, o_flags[3:0]);
    alu(CBAF_OP_SUB, 8'h05, 8'h05, 1'b1, 8'h00);
    chk("sub_eq", 32'h7, o_flags[3:0]);
    alu(CBAF_OP_SUB, 8'h00, 8'h01, 1'b1, 8'hFF);
    chk("sub_borrow", 32'h0, o_flags[3:0]);
    alu(CBAF_OP_ROTC, 8'h01, 8'h00, 1'b1, 8'h00);
    chk("rotc", 32'h1, o_flags[0]);
    alu(CBAF_OP_LOGIC, 8'h0F, 8'hF0, 1'b0, 8'h00);
    chk("logic_z", 32'h1, o_flags[2]);
    sys(3'b100);
    chk("halt", 32'h1, o_flags[5:4]);
    sys(3'b001);
    chk("expiry", 32'h3, o_flags[5:4]);
    apb(1'b1, 8'h04, 32'h00);
    rd(8'h04, 32'h30, "flags_keep");
    sys(3'b100);
    chk("halt_to", 32'h1, o_flags[5:4]);
    sys(3'b010);
    chk("watchdog_clear_instruction", 32'h0, o_flags[5:4]);
    $display("test flags done");
    complete_run();
  end
endmodule : testbench
